// ### logic/group_cfg_defines.svh
// How it works
// RQ1: Subchan off clear lets every slot subchannel
// RQ2: Subchan off set forbids subchannels, frees map
// RQ3: Transmit group off clears slots, floats data
// RQ4: Transmit group on passes mapped transmit slots
// RQ5: Receive group off clears all receive slots
// RQ6: Receive group on passes mapped receive slots
// RQ7: Group gating never alters stored slot maps
// RQ8: Host keeps protection on bit at zero
// RQ9: Protection word bits 27:16 hold upper bound
// RQ10: Protection word bits 11:0 hold lower bound
// RQ11: One port word drives transmit and receive
// RQ12: Pairing one: port1 equals 0, 3 equals 2
// RQ13: Pairing two: ports 1-3 equal port 0
// RQ14: Reserved protection bits written zero, ignored
`ifndef GROUP_CFG_DEFINES_SVH
`define GROUP_CFG_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define NUM_GROUPS 4
`define NUM_SLOTS 32

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_PAIRING 8'h00
`define OFS_STATUS 8'h04
`define OFS_GROUP0 8'h10
`define OFS_PROTECT 8'h20
`define OFS_PORT0 8'h30

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_SUBCHAN_OFF 2
`define BIT_TX_GROUP_ON 1
`define BIT_RX_GROUP_ON 0
`define BIT_PROT_ON 31
`define PROT_HI_MSB 27
`define PROT_HI_LSB 16
`define PROT_LO_MSB 11
`define PROT_LO_LSB 0
`define BIT_STAT_MISMATCH 0
`define BIT_STAT_PROT_ON 1

// ----------------------------------------
// Pairing codes and reset values
// ----------------------------------------
`define PAIR_TWO 2'h1
`define PAIR_FOUR 2'h2
`define RST_GROUP 3'h0
`define RST_PROT_ON 1'h0
`define RST_BOUND 12'h000
`define RST_PORT 32'h00000000
`define RST_PAIRING 2'h0

`endif

// ### logic/group_cfg_pkg.sv
`include "group_cfg_defines.svh"

package group_cfg_pkg;

  typedef logic [`NUM_GROUPS-1:0][`NUM_SLOTS-1:0] slot_map_t;
  typedef logic [`NUM_GROUPS-1:0][31:0] port_words_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_PAIRING = 3'h1,
    SEL_STATUS = 3'h3,
    SEL_GROUP = 3'h2,
    SEL_PROTECT = 3'h6,
    SEL_PORT = 3'h7
  } reg_sel_e;

  typedef struct packed {
    logic [`NUM_GROUPS-1:0][2:0] grp;
    logic prot_on;
    logic [11:0] prot_hi;
    logic [11:0] prot_lo;
    port_words_t port_cfg;
    logic [1:0] pairing;
    logic ack;
    logic [31:0] rdat;
    slot_map_t tx_act;
    slot_map_t rx_act;
    slot_map_t sub_act;
    logic [`NUM_GROUPS-1:0] tx_line;
    logic [`NUM_GROUPS-1:0] tx_oe;
    logic [`NUM_GROUPS-1:0] xbuf;
    logic mismatch;
    port_words_t port_tx;
    port_words_t port_rx;
  } cfg_state_s;

endpackage

// ### logic/group_enable_and_protection_cfg.sv
`timescale 1ns/10ps
`include "group_cfg_defines.svh"

module group_enable_and_protection_cfg (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire group_cfg_pkg::slot_map_t tx_slot_map,
  input wire group_cfg_pkg::slot_map_t rx_slot_map,
  input wire group_cfg_pkg::slot_map_t sub_slot_map,
  input wire logic [`NUM_GROUPS-1:0] tx_line_in,
  output logic [`NUM_GROUPS-1:0] tx_line_out,
  output logic [`NUM_GROUPS-1:0] tx_line_oe,
  output group_cfg_pkg::slot_map_t tx_slot_active,
  output group_cfg_pkg::slot_map_t rx_slot_active,
  output group_cfg_pkg::slot_map_t sub_slot_active,
  output logic [`NUM_GROUPS-1:0] extra_buffer_free,
  output group_cfg_pkg::port_words_t port_cfg_tx,
  output group_cfg_pkg::port_words_t port_cfg_rx,
  output logic [1:0] port_pairing_select,
  output logic protection_on,
  output logic [11:0] protect_upper_bound,
  output logic [11:0] protect_lower_bound,
  output logic pairing_mismatch
);
  import group_cfg_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic reg_sel_e decode(input logic [7:0] adr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (adr[1:0] == 2'h0) begin
      if (adr == `OFS_PAIRING) begin
        sel = SEL_PAIRING;
      end else if (adr == `OFS_STATUS) begin
        sel = SEL_STATUS;
      end else if (adr[7:4] == 4'(`OFS_GROUP0 >> 4)) begin
        sel = SEL_GROUP;
      end else if (adr == `OFS_PROTECT) begin
        sel = SEL_PROTECT;
      end else if (adr[7:4] == 4'(`OFS_PORT0 >> 4)) begin
        sel = SEL_PORT;
      end
    end
    return sel;
  endfunction

  function automatic logic [1:0] word_index(input logic [7:0] adr);
    return adr[3:2];
  endfunction

  // ----------------------------------------
  // Byte lane merge
  // ----------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  cfg_state_s st;
  cfg_state_s next_st;

  logic req;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [31:0] prot_word;
  logic [31:0] status_word;
  logic [31:0] wr_word;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr_sel = decode(wb_adr_i);
  assign rd_sel = decode(wb_adr_i);
  assign wr_idx = word_index(wb_adr_i);
  assign rd_idx = word_index(wb_adr_i);

  // ----------------------------------------
  // Read views
  // ----------------------------------------
  always_comb begin
    prot_word = 32'h00000000;
    prot_word[`BIT_PROT_ON] = st.prot_on;
    prot_word[`PROT_HI_MSB:`PROT_HI_LSB] = st.prot_hi;
    prot_word[`PROT_LO_MSB:`PROT_LO_LSB] = st.prot_lo;
    status_word = 32'h00000000;
    status_word[`BIT_STAT_MISMATCH] = st.mismatch;
    status_word[`BIT_STAT_PROT_ON] = st.prot_on;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    wr_word = 32'h00000000;

    // Bus answer: ack one cycle after request, then drop
    next_st.ack = req & ~st.ack;

    // Read data prepared while ack is low
    next_st.rdat = 32'h00000000;
    if (req && !st.ack && !wb_we_i) begin
      unique case (rd_sel)
        SEL_PAIRING: next_st.rdat = {30'h00000000, st.pairing};
        SEL_STATUS: next_st.rdat = status_word;
        SEL_GROUP: next_st.rdat = {29'h00000000, st.grp[rd_idx]};
        SEL_PROTECT: next_st.rdat = prot_word;
        SEL_PORT: next_st.rdat = st.port_cfg[rd_idx];
        SEL_NONE: next_st.rdat = 32'h00000000;
      endcase
    end

    // Writes commit on the edge after ack rises, as ack drops
    if (req && st.ack && wb_we_i) begin
      unique case (wr_sel)
        SEL_PAIRING: begin
          wr_word = merge({30'h00000000, st.pairing}, wb_dat_i, wb_sel_i);
          next_st.pairing = wr_word[1:0];
        end
        SEL_GROUP: begin
          wr_word = merge({29'h00000000, st.grp[wr_idx]}, wb_dat_i, wb_sel_i);
          next_st.grp[wr_idx] = wr_word[2:0];
        end
        SEL_PROTECT: begin
          wr_word = merge(prot_word, wb_dat_i, wb_sel_i);
          // Reserved bits dropped on write [RQ14]
          next_st.prot_on = wr_word[`BIT_PROT_ON];
          next_st.prot_hi = wr_word[`PROT_HI_MSB:`PROT_HI_LSB]; // [RQ9]
          next_st.prot_lo = wr_word[`PROT_LO_MSB:`PROT_LO_LSB]; // [RQ10]
        end
        SEL_PORT: begin
          wr_word = merge(st.port_cfg[wr_idx], wb_dat_i, wb_sel_i);
          next_st.port_cfg[wr_idx] = wr_word;
        end
        SEL_STATUS: wr_word = 32'h00000000;
        SEL_NONE: wr_word = 32'h00000000;
      endcase
    end

    // Group gating of slot maps, maps themselves untouched [RQ7]
    for (int g = 0; g < `NUM_GROUPS; g++) begin
      if (st.grp[g][`BIT_TX_GROUP_ON]) begin
        next_st.tx_act[g] = tx_slot_map[g]; // [RQ4]
      end else begin
        next_st.tx_act[g] = '0; // [RQ3]
      end
      if (st.grp[g][`BIT_RX_GROUP_ON]) begin
        next_st.rx_act[g] = rx_slot_map[g]; // [RQ6]
      end else begin
        next_st.rx_act[g] = '0; // [RQ5]
      end
      if (st.grp[g][`BIT_SUBCHAN_OFF]) begin
        next_st.sub_act[g] = '0; // [RQ2]
      end else begin
        next_st.sub_act[g] = '1; // [RQ1]
      end
      next_st.xbuf[g] = st.grp[g][`BIT_SUBCHAN_OFF]; // [RQ2]
      next_st.tx_oe[g] = st.grp[g][`BIT_TX_GROUP_ON]; // [RQ3]
      next_st.tx_line[g] = tx_line_in[g] & st.grp[g][`BIT_TX_GROUP_ON];
      // Same word feeds both directions [RQ11]
      next_st.port_tx[g] = st.port_cfg[g];
      next_st.port_rx[g] = st.port_cfg[g];
    end

    // Pairing consistency report
    unique case (st.pairing)
      `PAIR_TWO: next_st.mismatch = (st.port_cfg[1] != st.port_cfg[0]) |
        (st.port_cfg[3] != st.port_cfg[2]); // [RQ12]
      `PAIR_FOUR: next_st.mismatch = (st.port_cfg[1] != st.port_cfg[0]) |
        (st.port_cfg[2] != st.port_cfg[0]) |
        (st.port_cfg[3] != st.port_cfg[0]); // [RQ13]
      default: next_st.mismatch = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int g = 0; g < `NUM_GROUPS; g++) begin
        st.grp[g] <= `RST_GROUP;
        st.port_cfg[g] <= `RST_PORT;
        st.port_tx[g] <= `RST_PORT;
        st.port_rx[g] <= `RST_PORT;
        st.tx_act[g] <= '0;
        st.rx_act[g] <= '0;
        st.sub_act[g] <= '0;
      end
      st.prot_on <= `RST_PROT_ON;
      st.prot_hi <= `RST_BOUND;
      st.prot_lo <= `RST_BOUND;
      st.pairing <= `RST_PAIRING;
      st.ack <= 1'b0;
      st.rdat <= 32'h00000000;
      st.tx_line <= '0;
      st.tx_oe <= '0;
      st.xbuf <= '0;
      st.mismatch <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign tx_line_out = st.tx_line;
  assign tx_line_oe = st.tx_oe;
  assign tx_slot_active = st.tx_act;
  assign rx_slot_active = st.rx_act;
  assign sub_slot_active = st.sub_act;
  assign extra_buffer_free = st.xbuf;
  assign port_cfg_tx = st.port_tx;
  assign port_cfg_rx = st.port_rx;
  assign port_pairing_select = st.pairing;
  // Protection logic absent; bit only stored and reported [RQ8]
  assign protection_on = st.prot_on;
  assign protect_upper_bound = st.prot_hi;
  assign protect_lower_bound = st.prot_lo;
  assign pairing_mismatch = st.mismatch;

endmodule

// ### verif/group_cfg_assertions.sv
`timescale 1ns/10ps
`include "group_cfg_defines.svh"
module group_cfg_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire group_cfg_pkg::slot_map_t tx_slot_map,
  input wire group_cfg_pkg::slot_map_t rx_slot_map,
  input wire logic [`NUM_GROUPS-1:0] tx_line_in,
  input wire logic [`NUM_GROUPS-1:0] tx_line_out,
  input wire logic [`NUM_GROUPS-1:0] tx_line_oe,
  input wire group_cfg_pkg::slot_map_t tx_slot_active,
  input wire group_cfg_pkg::slot_map_t rx_slot_active,
  input wire group_cfg_pkg::slot_map_t sub_slot_active,
  input wire logic [`NUM_GROUPS-1:0] extra_buffer_free,
  input wire group_cfg_pkg::port_words_t port_cfg_tx,
  input wire group_cfg_pkg::port_words_t port_cfg_rx,
  input wire logic [11:0] protect_upper_bound
);
  import group_cfg_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr_done;
    wb_ack_o && wb_we_i;
  endsequence
  property p_ack_next;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_sub_on;
    sub_slot_active[0] != '0 |-> sub_slot_active[0] == '1 && !extra_buffer_free[0];
  endproperty
  property p_sub_off;
    extra_buffer_free[0] |-> sub_slot_active[0] == '0;
  endproperty
  property p_tx_gate;
    tx_slot_active[0] == ($past(tx_slot_map[0]) & {32{tx_line_oe[0]}});
  endproperty
  property p_tx_line;
    tx_line_out == ($past(tx_line_in) & tx_line_oe);
  endproperty
  property p_rx_gate;
    (rx_slot_active[0] & ~$past(rx_slot_map[0])) == '0;
  endproperty
  property p_port_same;
    port_cfg_tx == port_cfg_rx;
  endproperty
  property p_bound_hold;
    s_wr_done or ##1 $stable(protect_upper_bound);
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  a_sub_on: assert property (p_sub_on) else $error("partial subchannel map");
  a_sub_off: assert property (p_sub_off) else $error("subchannel left on");
  a_tx_gate: assert property (p_tx_gate) else $error("tx slot gating wrong");
  a_tx_line: assert property (p_tx_line) else $error("tx line wrong");
  a_rx_gate: assert property (p_rx_gate) else $error("rx slot outside map");
  a_port_same: assert property (p_port_same) else $error("port words differ");
  a_bound_hold: assert property (p_bound_hold) else $error("bound moved");
endmodule

bind group_enable_and_protection_cfg group_cfg_checker i_group_cfg_checker (.mclk, .arst_n,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .tx_slot_map, .rx_slot_map, .tx_line_in,
  .tx_line_out, .tx_line_oe, .tx_slot_active, .rx_slot_active, .sub_slot_active,
  .extra_buffer_free, .port_cfg_tx, .port_cfg_rx, .protect_upper_bound);

// ### verif/group_enable_and_protection_cfg_tb.sv
`timescale 1ns/10ps
`include "group_cfg_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module group_enable_and_protection_cfg_tb;
  import group_cfg_pkg::*;
  logic mclk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, ack, pon, mism;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0, tin = 0, tout, toe, xbuf;
  logic [31:0] wdat = 0, rd, dat_o;
  logic [11:0] hi, lo;
  logic [1:0] pair;
  slot_map_t txm = '0, rxm = '0, sbm = '0, tx_act, rx_act, sub_act;
  port_words_t pc_tx, pc_rx;
  int failures = 0, comparisons = 0;
  group_enable_and_protection_cfg i_group_enable_and_protection_cfg (.mclk(mclk),
    .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_slot_map(txm),
    .rx_slot_map(rxm), .sub_slot_map(sbm), .tx_line_in(tin), .tx_line_out(tout),
    .tx_line_oe(toe), .tx_slot_active(tx_act), .rx_slot_active(rx_act),
    .sub_slot_active(sub_act), .extra_buffer_free(xbuf), .port_cfg_tx(pc_tx),
    .port_cfg_rx(pc_rx), .port_pairing_select(pair), .protection_on(pon),
    .protect_upper_bound(hi), .protect_lower_bound(lo), .pairing_mismatch(mism));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task wb(input int w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= (w != 0);
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1);
    `CHK("ack wait", 2, n)
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(0, a, 32'h0, 4'h0);
    `CHK(nm, e, rd)
  endtask
  task settle;
    repeat (2) @(posedge mclk);
  endtask
  task wrap_up;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial forever #25 mclk = ~mclk;
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1;
    repeat (4) @(posedge mclk);
    `CHK("sub reset", '1, sub_act[0])
    rchk("grp0", 8'h10, 32'h0);
    wb(1, 8'h10, 32'h4, 4'hF);
    txm[0] <= 32'hA5A50F0F; rxm[0] <= 32'h12345678; sbm[0] <= 32'hFFFF0000; tin <= 4'hF;
    settle();
    `CHK("sub off", 32'h0, sub_act[0])
    `CHK("xbuf", 4'h1, xbuf)
    `CHK("tx off", 32'h0, tx_act[0])
    `CHK("oe off", 4'h0, toe)
    `CHK("rx off", 32'h0, rx_act[0])
    wb(1, 8'h10, 32'h3, 4'hF);
    settle();
    `CHK("tx on", 32'hA5A50F0F, tx_act[0])
    `CHK("tx line", 4'h1, tout)
    `CHK("rx on", 32'h12345678, rx_act[0])
    `CHK("sub on", '1, sub_act[0])
    wb(1, 8'h10, 32'h1, 4'hF);
    settle();
    `CHK("oe float", 4'h0, toe)
    wb(1, 8'h10, 32'h3, 4'hF);
    settle();
    `CHK("tx map kept", 32'hA5A50F0F, tx_act[0])
    wb(1, 8'h20, 32'h0ABC0DEF, 4'hF);
    settle();
    `CHK("upper", 12'hABC, hi)
    `CHK("lower", 12'hDEF, lo)
    `CHK("prot off", 1'b0, pon)
    wb(1, 8'h20, 32'h0FFF0F00, 4'h1);
    rchk("prot", 8'h20, 32'h0ABC0D00);
    for (int p = 0; p < 4; p++) wb(1, 8'h30 + 8'(4 * p), 32'h251, 4'hF);
    wb(1, 8'h00, 32'h2, 4'hF);
    settle();
    for (int p = 0; p < 4; p++) `CHK("port", 64'h251_00000251, {pc_tx[p], pc_rx[p]})
    `CHK("pair2", 3'h4, {pair, mism})
    wb(1, 8'h38, 32'h14, 4'hF);
    wb(1, 8'h3C, 32'h14, 4'hF);
    wb(1, 8'h00, 32'h1, 4'hF);
    settle();
    `CHK("pair1", 3'h2, {pair, mism})
    wb(1, 8'h3C, 32'h15, 4'hF);
    rchk("status", 8'h04, 32'h1);
    rchk("hole", 8'h08, 32'h0);
    rchk("odd", 8'h11, 32'h0);
    wrap_up();
  end
endmodule
